// [common/dma_ctl_pkg.sv]
// package for the dma channel control decode block
package dma_ctl_pkg;
  // register index of the channel control register (no printed offset)
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  // register index of the channel status word
  localparam logic [3:0]  REG_STATUS    = 4'h1;
  // register index of the transfer count
  localparam logic [3:0]  REG_COUNT     = 4'h2;
  // register index of the source pointer
  localparam logic [3:0]  REG_SRC       = 4'h3;
  // register index of the destination pointer
  localparam logic [3:0]  REG_DST       = 4'h4;

  // control register field positions
  localparam int BIT_DST_SPACE = 15;
  localparam int BIT_DST_DEC   = 14;
  localparam int BIT_DST_INC   = 13;
  localparam int BIT_SRC_SPACE = 12;
  localparam int BIT_SRC_DEC   = 11;
  localparam int BIT_SRC_INC   = 10;
  localparam int BIT_TC_EN     = 9;
  localparam int BIT_INT_EN    = 8;
  localparam int BIT_SYNC_HI   = 7;
  localparam int BIT_SYNC_LO   = 6;
  localparam int BIT_PRIO      = 5;
  localparam int BIT_INT_REQ   = 4;
  localparam int BIT_ARM_WE    = 2;
  localparam int BIT_ARM       = 1;
  localparam int BIT_WORD      = 0;

  // reset values; arm bit resets to zero
  localparam logic [15:0] CTRL_RESET    = 16'h0000;
  localparam logic [15:0] ZERO16        = 16'h0000;
  localparam logic [15:0] ONE16         = 16'h0001;
  localparam logic [15:0] STEP_BYTE     = 16'h0001;
  localparam logic [15:0] STEP_WORD     = 16'h0002;
  // control bits that hold state; reserved bit 3 and the write enable read zero
  localparam logic [15:0] CTRL_RW_MASK  = 16'hfff3;

  // synchronisation codes
  localparam logic [1:0]  SYNC_NONE     = 2'h0;
  localparam logic [1:0]  SYNC_SRC      = 2'h1;
  localparam logic [1:0]  SYNC_DST      = 2'h2;

  // register port request
  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } reg_req_t;

  // one transfer as presented to the bus sequencer
  typedef struct packed {
    logic        word;
    logic [15:0] src;
    logic [15:0] dst;
    logic        src_io;
    logic        dst_io;
  } xfer_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_XFER,
    ST_WAIT
  } chan_state_t;
endpackage : dma_ctl_pkg

// [core/dma_channel_control_decode.sv]
// one dma channel: control register decode, arming and transfer bookkeeping
//
// Contract
// R01: width bit one moves 16-bit words
// R02: width bit zero moves bytes
// R03: pointers step two word, one byte
// R04: synchronized channel stops at zero if enabled
// R05: unsynchronized mode always stops at zero
// R06: interrupt needs interrupt and stop enables
// R07: sync codes none, source, destination
// R08: software never writes sync code 11
// R09: priority bit gives high priority
// R10: internal select ignores external request pin
// R11: internal requests require source sync
// R12: arm bit written only with write enable
// R13: arm bit arms channel, resets zero
// R14: 8-bit bus variants ignore width bit
// R15: software writes zero to reserved bits
// R16: channel self-disarms at zero when stopping
// R17: unsynchronized starts at once when armed
// R18: count decrements by one per transfer
// R19: equal step bits hold pointer constant
// R20: control bit layout as fixed
//
// The address-and-strobe port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control_decode
  import dma_ctl_pkg::*;
#(
  parameter bit NARROW_BUS = 1'b0
) (
  // clock, reset, enable
  input  wire logic        sys_clk_in,
  input  wire logic        rst_in,
  input  wire logic        clk_en_in,
  // register port
  input  wire reg_req_t    reg_req_in,
  output logic [15:0]      reg_rdata_out,
  // request sources
  input  wire logic        external_request_pin_in,
  input  wire logic        internal_request_in,
  // bus sequencer handshake
  output logic             xfer_req_out,
  output xfer_t            xfer_out,
  input  wire logic        xfer_done_in,
  // decoded status
  output logic             high_priority_out,
  output logic             tc_irq_out,
  output logic             armed_out
);

  typedef struct packed {
    logic [15:0] ctrl;
    logic [15:0] count;
    logic [15:0] src;
    logic [15:0] dst;
    logic [15:0] rdata;
    logic        irq;
    chan_state_t st;
  } state_t;

  state_t s_q;
  state_t s_d;

  // pointer step: word or byte size, direction from the two bits
  function automatic logic [15:0] step_ptr(input logic [15:0] p, input logic inc,
                                           input logic dec, input logic word);
    logic [15:0] amt;
    amt = word ? STEP_WORD : STEP_BYTE; // [R03]
    if (inc == dec) begin
      step_ptr = p; // [R19]
    end else if (inc) begin
      step_ptr = p + amt;
    end else begin
      step_ptr = p - amt;
    end
  endfunction

  logic [1:0]  sync_select;
  logic        word_mode;
  logic        stop_at_zero_count;
  logic        req_seen;
  logic        count_last;

  // field decode
  always_comb begin
    sync_select        = {s_q.ctrl[BIT_SYNC_HI], s_q.ctrl[BIT_SYNC_LO]}; // [R07] [R20]
    word_mode          = s_q.ctrl[BIT_WORD] & ~NARROW_BUS; // [R01] [R02] [R14]
    // unsynchronized transfers stop at zero as if the stop bit were set
    stop_at_zero_count = s_q.ctrl[BIT_TC_EN] | (sync_select == SYNC_NONE); // [R04] [R05]
    // internal select masks the pin entirely; source sync assumed there
    req_seen           = s_q.ctrl[BIT_INT_REQ] ? internal_request_in
                                               : external_request_pin_in; // [R10] [R11]
    count_last         = (s_q.count == ONE16);
  end

  // next state
  always_comb begin
    s_d       = s_q;
    s_d.irq   = 1'b0;
    s_d.rdata = ZERO16;
    case (s_q.st)
      ST_IDLE: begin
        if (s_q.ctrl[BIT_ARM]) begin // [R13]
          // unsynchronized goes without any request; code 11 is left undefined
          if (sync_select == SYNC_NONE || req_seen) begin // [R17] [R08]
            s_d.st = ST_XFER;
          end
        end
      end
      ST_XFER: begin
        if (xfer_done_in) begin
          s_d.count = s_q.count - ONE16; // [R18]
          s_d.src   = step_ptr(s_q.src, s_q.ctrl[BIT_SRC_INC], s_q.ctrl[BIT_SRC_DEC], word_mode);
          s_d.dst   = step_ptr(s_q.dst, s_q.ctrl[BIT_DST_INC], s_q.ctrl[BIT_DST_DEC], word_mode);
          s_d.st    = ST_WAIT;
          if (count_last && stop_at_zero_count) begin
            s_d.ctrl[BIT_ARM] = 1'b0; // [R16]
            // interrupt only when the real stop bit is set too
            s_d.irq = s_q.ctrl[BIT_INT_EN] & s_q.ctrl[BIT_TC_EN]; // [R06]
          end
        end
      end
      ST_WAIT: begin
        // one idle cycle lets a level request fall before it is sampled again
        s_d.st = ST_IDLE;
      end
      default: begin
        s_d.st = ST_IDLE;
      end
    endcase
    // register writes; software write comes after hardware disarm
    if (reg_req_in.wr) begin
      case (reg_req_in.addr)
        REG_CTRL: begin
          s_d.ctrl = (reg_req_in.wdata & CTRL_RW_MASK & ~(ONE16 << BIT_ARM))
                   | (s_d.ctrl & (ONE16 << BIT_ARM)); // [R15]
          if (reg_req_in.wdata[BIT_ARM_WE]) begin
            s_d.ctrl[BIT_ARM] = reg_req_in.wdata[BIT_ARM]; // [R12]
          end
        end
        REG_COUNT: s_d.count = reg_req_in.wdata;
        REG_SRC:   s_d.src   = reg_req_in.wdata;
        REG_DST:   s_d.dst   = reg_req_in.wdata;
        default:   s_d.count = s_d.count;
      endcase
    end
    // read data for the next cycle; unmapped reads return zero
    if (reg_req_in.rd) begin
      case (reg_req_in.addr)
        REG_CTRL:   s_d.rdata = s_q.ctrl;
        REG_STATUS: s_d.rdata = {13'h0000, (s_q.st == ST_XFER), s_q.ctrl[BIT_PRIO], s_q.ctrl[BIT_ARM]};
        REG_COUNT:  s_d.rdata = s_q.count;
        REG_SRC:    s_d.rdata = s_q.src;
        REG_DST:    s_d.rdata = s_q.dst;
        default:    s_d.rdata = ZERO16;
      endcase
    end
  end

  // state register, frozen while the enable is low
  always_ff @(posedge sys_clk_in) begin
    if (rst_in) begin
      s_q <= '{ctrl: CTRL_RESET, count: ZERO16, src: ZERO16, dst: ZERO16,
               rdata: ZERO16, irq: 1'b0, st: ST_IDLE};
    end else if (clk_en_in) begin
      s_q <= s_d;
    end
  end

  // outputs
  assign reg_rdata_out     = s_q.rdata;
  assign xfer_req_out      = (s_q.st == ST_XFER);
  assign xfer_out          = '{word: word_mode, src: s_q.src, dst: s_q.dst,
                               src_io: ~s_q.ctrl[BIT_SRC_SPACE], dst_io: ~s_q.ctrl[BIT_DST_SPACE]};
  assign high_priority_out = s_q.ctrl[BIT_PRIO]; // [R09]
  assign tc_irq_out        = s_q.irq;
  assign armed_out         = s_q.ctrl[BIT_ARM];

  // a write without the write enable keeps the arm bit
  property p_arm_guard;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && reg_req_in.wr && reg_req_in.addr == REG_CTRL && !reg_req_in.wdata[BIT_ARM_WE]
       && s_q.st != ST_XFER) |=> (armed_out == $past(armed_out));
  endproperty
  a_arm_guard: assert property (p_arm_guard) else $error("arm bit changed without write enable"); // [R12]

  property p_arm_set;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && reg_req_in.wr && reg_req_in.addr == REG_CTRL && reg_req_in.wdata[BIT_ARM_WE])
      |=> (armed_out == $past(reg_req_in.wdata[BIT_ARM]));
  endproperty
  a_arm_set: assert property (p_arm_set) else $error("arm bit did not follow enabled write"); // [R13]

  property p_count_dec;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && xfer_req_out && xfer_done_in && !(reg_req_in.wr && reg_req_in.addr == REG_COUNT))
      |=> (s_q.count == $past(s_q.count) - ONE16);
  endproperty
  a_count_dec: assert property (p_count_dec) else $error("count did not drop by one"); // [R18]

  property p_irq_cause;
    @(posedge sys_clk_in) disable iff (rst_in)
      // a frozen pulse outlives its cause, so only the cycle that loaded it is judged
      (tc_irq_out && $past(clk_en_in))
      |-> ($past(s_q.ctrl[BIT_INT_EN]) && $past(s_q.ctrl[BIT_TC_EN]) && $past(count_last));
  endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("interrupt without both enables"); // [R06]

  property p_word_step;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && xfer_req_out && xfer_done_in && word_mode && s_q.ctrl[BIT_SRC_INC]
       && !s_q.ctrl[BIT_SRC_DEC] && !(reg_req_in.wr && reg_req_in.addr == REG_SRC))
      |=> (s_q.src == $past(s_q.src) + STEP_WORD);
  endproperty
  a_word_step: assert property (p_word_step) else $error("word step not two"); // [R03] [R01]

  property p_hold_ptr;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && xfer_req_out && xfer_done_in && s_q.ctrl[BIT_DST_INC] == s_q.ctrl[BIT_DST_DEC]
       && !(reg_req_in.wr && reg_req_in.addr == REG_DST)) |=> $stable(s_q.dst);
  endproperty
  a_hold_ptr: assert property (p_hold_ptr) else $error("pointer moved with equal step bits"); // [R19]

  property p_unsync_start;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && s_q.st == ST_IDLE && armed_out && sync_select == SYNC_NONE)
      |=> xfer_req_out;
  endproperty
  a_unsync_start: assert property (p_unsync_start) else $error("unsynchronized channel did not start"); // [R17]

  property p_self_disarm;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && xfer_req_out && xfer_done_in && count_last && stop_at_zero_count && !reg_req_in.wr)
      |=> !armed_out ##1 !xfer_req_out;
  endproperty
  a_self_disarm: assert property (p_self_disarm) else $error("channel did not disarm at zero"); // [R16] [R05]

  property p_pin_ignored;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && s_q.st == ST_IDLE && s_q.ctrl[BIT_INT_REQ] && !internal_request_in
       && sync_select != SYNC_NONE) |=> !xfer_req_out;
  endproperty
  a_pin_ignored: assert property (p_pin_ignored) else $error("external pin used under internal select"); // [R10]

  // byte transfers move an incrementing pointer by one
  property p_byte_step;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && xfer_req_out && xfer_done_in && !word_mode && s_q.ctrl[BIT_SRC_INC]
       && !s_q.ctrl[BIT_SRC_DEC] && !(reg_req_in.wr && reg_req_in.addr == REG_SRC))
      |=> (s_q.src == $past(s_q.src) + STEP_BYTE);
  endproperty
  a_byte_step: assert property (p_byte_step) else $error("byte step not one"); // [R02] [R03]

  // a decrementing pointer steps down by the transfer size
  property p_dst_down;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && xfer_req_out && xfer_done_in && s_q.ctrl[BIT_DST_DEC] && !s_q.ctrl[BIT_DST_INC]
       && !(reg_req_in.wr && reg_req_in.addr == REG_DST))
      |=> (s_q.dst == $past(s_q.dst) - ($past(word_mode) ? STEP_WORD : STEP_BYTE));
  endproperty
  a_dst_down: assert property (p_dst_down) else $error("decrementing pointer stepped wrong"); // [R03]

  // stop bit clear on a synchronized channel: still armed past zero
  property p_keep_armed;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && xfer_req_out && xfer_done_in && count_last && !stop_at_zero_count && !reg_req_in.wr)
      |=> armed_out;
  endproperty
  a_keep_armed: assert property (p_keep_armed) else $error("channel stopped with stop bit clear"); // [R04]

  // both enables set: the last transfer raises the interrupt
  property p_irq_at_zero;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && xfer_req_out && xfer_done_in && count_last && s_q.ctrl[BIT_INT_EN] && s_q.ctrl[BIT_TC_EN])
      |=> tc_irq_out;
  endproperty
  a_irq_at_zero: assert property (p_irq_at_zero) else $error("no interrupt at terminal count"); // [R06]

  // unsynchronized stops at zero without the stop bit, and stays quiet
  property p_unsync_stop;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && xfer_req_out && xfer_done_in && count_last && sync_select == SYNC_NONE
       && !s_q.ctrl[BIT_TC_EN] && !reg_req_in.wr) |=> (!armed_out && !tc_irq_out);
  endproperty
  a_unsync_stop: assert property (p_unsync_stop) else $error("unsynchronized channel ran past zero"); // [R05]

  // a disarmed channel never starts
  property p_unarmed_quiet;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && s_q.st == ST_IDLE && !armed_out) |=> !xfer_req_out;
  endproperty
  a_unarmed_quiet: assert property (p_unarmed_quiet) else $error("transfer started while disarmed"); // [R13]

  // priority output follows every accepted control write
  property p_prio_write;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && reg_req_in.wr && reg_req_in.addr == REG_CTRL) |=> (high_priority_out == $past(reg_req_in.wdata[BIT_PRIO]));
  endproperty
  a_prio_write: assert property (p_prio_write) else $error("priority did not follow write"); // [R09]

  // external select: the pin alone starts a synchronized transfer
  property p_pin_used;
    @(posedge sys_clk_in) disable iff (rst_in)
      (clk_en_in && s_q.st == ST_IDLE && armed_out && !s_q.ctrl[BIT_INT_REQ] && sync_select != SYNC_NONE
       && external_request_pin_in) |=> xfer_req_out;
  endproperty
  a_pin_used: assert property (p_pin_used) else $error("external pin request not taken"); // [R10]

endmodule : dma_channel_control_decode
`default_nettype wire

// [bench/seq_model.sv]
// bus sequencer stand-in: finishes each requested transfer after a set delay
`timescale 1ns/1ps
`default_nettype none
module seq_model (
  // clock and reset
  input  wire logic       sys_clk_in,
  input  wire logic       rst_in,
  // transfer handshake
  input  wire logic       req_in,
  input  wire logic [1:0] delay_in,
  output logic            done_out
);
  logic [1:0] cnt_q;

  // one done pulse per request; delay_in holds it back to mimic a slow bus
  always_ff @(posedge sys_clk_in) begin
    if (rst_in || !req_in || done_out) begin
      cnt_q    <= 2'h0;
      done_out <= 1'b0;
    end else begin
      done_out <= (cnt_q == delay_in);
      cnt_q    <= cnt_q + 2'h1;
    end
  end
endmodule // seq_model
`default_nettype wire

// [bench/dma_channel_control_decode_tb_top.sv]
// self-checking bench for the channel control decode block
`timescale 1ns/1ps
`default_nettype none
module dma_channel_control_decode_tb_top;
  import dma_ctl_pkg::*;
  logic        sys_clk_in, rst_in, ext_q, int_q, done, xreq, prio, irq, armed, stop, en_q;
  logic [1:0]  dly;
  logic [15:0] rdata, cfg, s, d, n, s8, d8;
  reg_req_t    req_q;
  xfer_t       xfer, xfer8;
  int          n_errors, tests_run, cycles, irq_cnt, ic, seed;

  dma_channel_control_decode DUT (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(en_q),
    .reg_req_in(req_q), .reg_rdata_out(rdata),
    .external_request_pin_in(ext_q), .internal_request_in(int_q),
    .xfer_req_out(xreq), .xfer_out(xfer), .xfer_done_in(done),
    .high_priority_out(prio), .tc_irq_out(irq), .armed_out(armed)
  );
  // 8-bit bus variant in lockstep; only its transfer description is watched
  dma_channel_control_decode #(.NARROW_BUS(1'b1)) DUT_NARROW (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .clk_en_in(en_q),
    .reg_req_in(req_q), .reg_rdata_out(),
    .external_request_pin_in(ext_q), .internal_request_in(int_q),
    .xfer_req_out(), .xfer_out(xfer8), .xfer_done_in(done),
    .high_priority_out(), .tc_irq_out(), .armed_out()
  );
  seq_model seq (
    .sys_clk_in(sys_clk_in), .rst_in(rst_in), .req_in(xreq), .delay_in(dly), .done_out(done)
  );

  // free-running clock, 50 ns period
  initial begin
    sys_clk_in = 1'b0;
    forever #25 sys_clk_in = ~sys_clk_in;
  end

  // interrupt pulse tally and hang guard
  always @(posedge sys_clk_in) begin
    cycles <= cycles + 1;
    if (irq === 1'b1) irq_cnt <= irq_cnt + 1;
    if (cycles == 40000) begin
      n_errors++;
      results();
    end
  end

  task automatic results();
    if (n_errors == 0 && tests_run > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge sys_clk_in);
    req_q <= '{a, v, 1'b1, 1'b0};
    @(posedge sys_clk_in);
    req_q <= '0;
  endtask

  // read data stands only in the cycle after the strobe
  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    @(posedge sys_clk_in);
    req_q <= '{a, 16'h0, 1'b0, 1'b1};
    @(posedge sys_clk_in);
    req_q <= '0;
    @(negedge sys_clk_in);
    check(rdata, exp);
  endtask

  // bounded wait for the transfer request to reach a level
  task automatic wait_for(input logic lvl);
    int i;
    i = 0;
    while (xreq !== lvl && i < 60) begin
      @(negedge sys_clk_in);
      i++;
    end
    check(xreq, lvl);
  endtask

  function automatic logic [15:0] step(logic [15:0] p, logic inc, logic dec, logic w);
    if (inc == dec) return p;
    return inc ? p + (w ? STEP_WORD : STEP_BYTE) : p - (w ? STEP_WORD : STEP_BYTE);
  endfunction

  initial begin
    seed = 32'h027b;
    {rst_in, ext_q, int_q, dly, req_q} = '0;
    en_q = 1'b1;
    rst_in = 1'b1;
    {n_errors, tests_run, cycles, irq_cnt} = '0;
    repeat (12) @(posedge sys_clk_in);
    rst_in <= 1'b0;
    check(armed, 1'b0);
    rd(REG_CTRL, CTRL_RESET);
    rd(4'hf, ZERO16);
    for (int it = 0; it < 12; it++) begin
      // reserved, write-enable and arm bits zero in the base word
      cfg = $random(seed) & 16'hfff1;
      if (it == 0) cfg[9:4] = 6'h10;
      if (it == 1) cfg[9:4] = 6'h08;
      if (cfg[7:6] == 2'h3) cfg[7:6] = SYNC_SRC;
      if (cfg[BIT_INT_REQ]) cfg[7:6] = SYNC_SRC;
      n = 16'h1 + ($random(seed) & 16'h3);
      s = $random(seed);
      d = $random(seed);
      s8 = s;
      d8 = d;
      dly = $random(seed);
      stop = cfg[BIT_TC_EN] | (cfg[7:6] == SYNC_NONE);
      wr(REG_CTRL, cfg | 16'h0004);
      wr(REG_CTRL, cfg | 16'h0002);
      @(negedge sys_clk_in);
      check(armed, 1'b0);
      rd(REG_CTRL, cfg);
      check(prio, cfg[BIT_PRIO]);
      // clock enable low: an arming write is lost and nothing moves
      @(posedge sys_clk_in);
      en_q <= 1'b0;
      wr(REG_CTRL, cfg | 16'h0006);
      @(negedge sys_clk_in);
      check(armed, 1'b0);
      @(posedge sys_clk_in);
      en_q <= 1'b1;
      wr(REG_COUNT, n);
      wr(REG_SRC, s);
      wr(REG_DST, d);
      ic = irq_cnt;
      wr(REG_CTRL, cfg | 16'h0006);
      if (cfg[7:6] != SYNC_NONE) begin
        // unselected source first: must not start anything
        ext_q <= cfg[BIT_INT_REQ];
        int_q <= !cfg[BIT_INT_REQ];
        repeat (6) @(negedge sys_clk_in);
        check(xreq, 1'b0);
        check(armed, 1'b1);
        @(posedge sys_clk_in);
        ext_q <= !cfg[BIT_INT_REQ];
        int_q <= cfg[BIT_INT_REQ];
      end
      for (int k = 0; k < n; k++) begin
        wait_for(1'b1);
        check(xfer, xfer_t'{cfg[0], s, d, !cfg[12], !cfg[15]});
        check(xfer8, xfer_t'{1'b0, s8, d8, !cfg[12], !cfg[15]});
        if (k == n - 1) begin
          @(posedge sys_clk_in);
          ext_q <= 1'b0;
          int_q <= 1'b0;
        end
        wait_for(1'b0);
        s = step(s, cfg[BIT_SRC_INC], cfg[BIT_SRC_DEC], cfg[0]);
        d = step(d, cfg[BIT_DST_INC], cfg[BIT_DST_DEC], cfg[0]);
        s8 = step(s8, cfg[BIT_SRC_INC], cfg[BIT_SRC_DEC], 1'b0);
        d8 = step(d8, cfg[BIT_DST_INC], cfg[BIT_DST_DEC], 1'b0);
      end
      repeat (4) @(negedge sys_clk_in);
      check(armed, !stop);
      check(irq_cnt - ic, cfg[BIT_TC_EN] & cfg[BIT_INT_EN]);
      check(xreq, 1'b0);
      rd(REG_COUNT, ZERO16);
      rd(REG_STATUS, {14'h0, cfg[BIT_PRIO], !stop});
      if (!stop) begin
        // stop bit clear: a request past zero still starts a transfer
        @(posedge sys_clk_in);
        ext_q <= !cfg[BIT_INT_REQ];
        int_q <= cfg[BIT_INT_REQ];
        wait_for(1'b1);
        @(posedge sys_clk_in);
        ext_q <= 1'b0;
        int_q <= 1'b0;
        wait_for(1'b0);
      end
    end
    results();
  end
endmodule // dma_channel_control_decode_tb_top
`default_nettype wire
